// ### gotr_pkg.sv
// Package for the gyro offset and trim register bank.
// Assumes an APB slave with word-aligned registers, byte data in bits 7:0.
package gotr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_TC_HIGH [3] = '{6'h04, 6'h07, 6'h0A};
    localparam logic [5:0] IDX_TC_LOW  [3] = '{6'h05, 6'h08, 6'h0B};
    localparam logic [5:0] IDX_SELFTEST_CODE_VALUE [3] = '{6'h0D, 6'h0E, 6'h0F};
    localparam logic [5:0] IDX_USR_HIGH    = 6'h13;
    localparam logic [5:0] IDX_USR_LOW     = 6'h14;
    localparam logic [5:0] IDX_PWR_CTRL    = 6'h20;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int LP_MSB        = 7;
    localparam int LP_LSB        = 2;
    localparam int TC_HI_MSB     = 1;
    localparam int PWR_SLEEP_BIT = 0;
    localparam int PWR_RESET_BIT = 7;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        SLEEP_RST = 1'b1;
    localparam logic [15:0] USR_RST   = 16'h0000;
    localparam logic [9:0]  TC_RST    = 10'h000;
    localparam logic [5:0]  LP_RST    = 6'h00;
    localparam logic [7:0]  ST_RST    = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Compensation scale: micro-dps per degree C per coefficient step
    localparam int TC_STEP_UDPS = 2520;
    localparam int TC_FRAC_BITS = 16;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_RUN  = 2'b01
    } gotr_state_t;

endpackage : gotr_pkg

// ### gotr_regs.sv
// Gyro offset trim register bank with APB slave and offset datapath.
// Assumes trim inputs are stable from reset release and samples are
// synchronous to pclk; temp_delta is whole degrees C from reference.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps

module gotr_regs #(
    parameter int GYRO_LSB_UDPS = 1000
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [2:0][9:0]       trim_tc,
    input  wire logic [2:0][5:0]       trim_lp,
    input  wire logic [2:0][7:0]       trim_st,
    input  wire logic                  raw_valid,
    input  wire logic [2:0][15:0]      gyro_raw,
    input  wire logic [7:0]            temp_delta,
    output logic      [2:0][15:0]      gyro_out,
    output logic                       out_valid,
    output logic                       sleep_mode
);
    import gotr_pkg::*;

    localparam int TC_GAIN_I = TC_STEP_UDPS * (2 ** TC_FRAC_BITS) / GYRO_LSB_UDPS;
    localparam logic signed [20:0] TC_GAIN = 21'(TC_GAIN_I);

    // Gain must fit 21 signed bits
    if (GYRO_LSB_UDPS < 1 || TC_GAIN_I >= (2 ** 20)) begin : g_chk
        $error("GYRO_LSB_UDPS too small");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    gotr_state_t     state_reg;
    logic [9:0]      tc_reg [3];
    logic [5:0]      lp_reg [3];
    logic [7:0]      st_reg [3];
    logic [15:0]     usr_reg;
    logic            sleep_reg;
    logic            pready_reg;
    logic            pslverr_reg;
    logic [31:0]     prdata_reg;
    logic [2:0][15:0] out_reg;
    logic            out_valid_reg;

    logic            pready_next;
    logic            done;
    logic            wr_en;
    logic [5:0]      idx;
    logic [7:0]      wbyte;
    logic [7:0]      rd_byte;
    logic            rd_mapped;
    logic            loading;
    logic            take;

    assign idx     = paddr[7:2];
    assign wbyte   = pwdata[7:0];
    assign loading = (state_reg == ST_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // Corrected sample, saturated to 16 bits
    function automatic logic [15:0] correct(
        input logic [15:0] raw,
        input logic [9:0]  coeff,
        input logic [7:0]  temp,
        input logic [15:0] usr
    );
        logic signed [39:0] prod;
        logic signed [23:0] sum;
        prod = $signed(coeff) * $signed(temp);
        prod = prod * TC_GAIN;
        sum  = 24'($signed(raw)) + 24'(prod >>> TC_FRAC_BITS) + 24'($signed(usr));
        if (sum > 24'sh007FFF) begin
            correct = 16'h7FFF;
        end else if (sum < -24'sh008000) begin
            correct = 16'h8000;
        end else begin
            correct = sum[15:0];
        end
    endfunction : correct

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    always_comb begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (idx == IDX_TC_HIGH[i]) begin
                rd_byte   = {lp_reg[i], tc_reg[i][9:8]};
                rd_mapped = 1'b1;
            end
            if (idx == IDX_TC_LOW[i]) begin
                rd_byte   = tc_reg[i][7:0];
                rd_mapped = 1'b1;
            end
            if (idx == IDX_SELFTEST_CODE_VALUE[i]) begin
                rd_byte   = st_reg[i];
                rd_mapped = 1'b1;
            end
        end
        case (idx)
            IDX_USR_HIGH: begin
                rd_byte   = usr_reg[15:8];
                rd_mapped = 1'b1;
            end
            IDX_USR_LOW: begin
                rd_byte   = usr_reg[7:0];
                rd_mapped = 1'b1;
            end
            IDX_PWR_CTRL: begin
                rd_byte   = {7'h00, sleep_reg};
                rd_mapped = 1'b1;
            end
            default: begin
            end
        endcase
        if (paddr[1:0] != 2'b00) begin
            rd_byte   = 8'h00;
            rd_mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: one wait state, held off while trims load
    assign pready_next = psel & penable & ~pready_reg & ~loading;
    assign done        = psel & penable & pready_reg;
    assign wr_en       = done & pwrite & pstrb[0] & ~pslverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            if (pready_next) begin
                pslverr_reg <= ~rd_mapped;
                prdata_reg  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load sequencer; device reset bit returns here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_LOAD;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (wr_en && idx == IDX_PWR_CTRL && wbyte[PWR_RESET_BIT]) begin
                        state_reg <= ST_LOAD;
                    end
                end
                default: begin
                    state_reg <= ST_LOAD;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim registers; reload wins over any earlier software value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                tc_reg[i] <= TC_RST;
                lp_reg[i] <= LP_RST;
                st_reg[i] <= ST_RST;
            end
        end else if (loading) begin
            for (int i = 0; i < 3; i++) begin
                tc_reg[i] <= trim_tc[i];
                lp_reg[i] <= trim_lp[i];
                st_reg[i] <= trim_st[i];
            end
        end else if (wr_en) begin
            for (int i = 0; i < 3; i++) begin
                if (idx == IDX_TC_HIGH[i]) begin
                    lp_reg[i]       <= wbyte[LP_MSB:LP_LSB];
                    tc_reg[i][9:8]  <= wbyte[TC_HI_MSB:0];
                end
                if (idx == IDX_TC_LOW[i]) begin
                    tc_reg[i][7:0]  <= wbyte;
                end
                if (idx == IDX_SELFTEST_CODE_VALUE[i]) begin
                    st_reg[i] <= wbyte;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User offset, one byte per write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usr_reg <= USR_RST;
        end else if (loading) begin
            usr_reg <= USR_RST;
        end else if (wr_en && idx == IDX_USR_HIGH) begin
            usr_reg[15:8] <= wbyte;
        end else if (wr_en && idx == IDX_USR_LOW) begin
            usr_reg[7:0] <= wbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_reg <= SLEEP_RST;
        end else if (loading) begin
            sleep_reg <= SLEEP_RST;
        end else if (wr_en && idx == IDX_PWR_CTRL) begin
            sleep_reg <= wbyte[PWR_SLEEP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample path; samples are dropped while asleep
    assign take = raw_valid & ~sleep_reg & ~loading;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_reg <= 1'b0;
            out_reg       <= '0;
        end else begin
            out_valid_reg <= take;
            if (take) begin
                // Compensation has no enable; coefficient alone decides
                for (int i = 0; i < 3; i++) begin
                    out_reg[i] <= correct(gyro_raw[i], tc_reg[i], temp_delta,
                                          (i == 0) ? usr_reg : 16'h0000);
                end
            end
        end
    end

    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign gyro_out   = out_reg;
    assign out_valid  = out_valid_reg;
    assign sleep_mode = sleep_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_sleep_load;
        @(posedge pclk) disable iff (!presetn)
        loading |=> sleep_reg && !out_valid_reg;
    endproperty
    a_sleep_load: assert property (p_sleep_load)
        else $error("not asleep after load");

    property p_tc_load;
        @(posedge pclk) disable iff (!presetn)
        loading |=> tc_reg[1] == $past(trim_tc[1]) && usr_reg == 16'h0000;
    endproperty
    a_tc_load: assert property (p_tc_load)
        else $error("trim not loaded");

    property p_tc_low_wr;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_TC_LOW[2] |=> tc_reg[2][7:0] == $past(wbyte)
            && $stable(tc_reg[2][9:8]);
    endproperty
    a_tc_low_wr: assert property (p_tc_low_wr)
        else $error("coefficient low write lost");

    property p_lp_wr;
        @(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_TC_HIGH[0] |=> lp_reg[0] == $past(wbyte[7:2])
            && tc_reg[0][9:8] == $past(wbyte[1:0]);
    endproperty
    a_lp_wr: assert property (p_lp_wr)
        else $error("high register write wrong");

    property p_zero_coeff;
        @(posedge pclk) disable iff (!presetn)
        take && tc_reg[1] == 10'h000 |=> gyro_out[1] == $past(gyro_raw[1]);
    endproperty
    a_zero_coeff: assert property (p_zero_coeff)
        else $error("zero coefficient changed output");

    property p_user_add;
        @(posedge pclk) disable iff (!presetn)
        take && tc_reg[0] == 10'h000 && gyro_raw[0] == 16'h0000
            |=> gyro_out[0] == $past(usr_reg);
    endproperty
    a_user_add: assert property (p_user_add)
        else $error("user offset not added");

    property p_st_read;
        @(posedge pclk) disable iff (!presetn)
        pready_next && !pwrite && paddr == {IDX_SELFTEST_CODE_VALUE[1], 2'b00}
            |=> prdata_reg == {24'h00_0000, st_reg[1]};
    endproperty
    a_st_read: assert property (p_st_read)
        else $error("self-test read wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        pready_next && !rd_mapped |=> pslverr_reg && prdata_reg == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_ready_bound;
        @(posedge pclk) disable iff (!presetn)
        psel && penable |-> ##[0:2] pready_reg;
    endproperty
    a_ready_bound: assert property (p_ready_bound)
        else $error("pready late");

    property p_sleep_drop;
        @(posedge pclk) disable iff (!presetn)
        raw_valid && sleep_reg |=> !out_valid_reg;
    endproperty
    a_sleep_drop: assert property (p_sleep_drop)
        else $error("sample taken while asleep");

    property p_st_load;
        @(posedge pclk) disable iff (!presetn)
        loading |=> st_reg[0] == $past(trim_st[0]) && lp_reg[2] == $past(trim_lp[2]);
    endproperty
    a_st_load: assert property (p_st_load)
        else $error("self-test code not loaded");

    property p_strb_off;
        @(posedge pclk) disable iff (!presetn)
        done && pwrite && !pstrb[0] |=> $stable(tc_reg[1]) && $stable(usr_reg);
    endproperty
    a_strb_off: assert property (p_strb_off)
        else $error("write without strobe took effect");

    c_user_wr: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && idx == IDX_USR_LOW);
    c_dev_reset: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(loading));
    c_sample: cover property (@(posedge pclk) disable iff (!presetn)
        take && tc_reg[0] != 10'h000);
    c_zero_user: cover property (@(posedge pclk) disable iff (!presetn)
        take && tc_reg[0] == 10'h000 && gyro_raw[0] == 16'h0000);
    c_refused: cover property (@(posedge pclk) disable iff (!presetn)
        done && pslverr_reg);

endmodule : gotr_regs

// ### gotr_tb.sv
// Self-checking bench for the gyro offset trim register bank.
// Assumes gotr_pkg and gotr_regs are compiled first; the bench is the APB master.
`timescale 1ns/10ps
module testbench;
    import gotr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    localparam int     LSB  = 1000;
    localparam longint GAIN = TC_STEP_UDPS * 65536 / LSB;

    logic                pclk       = 1'b0;
    logic                presetn    = 1'b0;
    logic                psel       = 1'b0;
    logic                penable    = 1'b0;
    logic                pwrite     = 1'b0;
    logic                raw_valid  = 1'b0;
    logic [7:0]          paddr      = 8'h00;
    logic [7:0]          temp_delta = 8'h00;
    logic [31:0]         pwdata     = 32'h0;
    logic [3:0]          pstrb      = 4'h0;
    logic [2:0][15:0]    gyro_raw   = '0;
    logic [2:0][9:0]     trim_tc;
    logic [2:0][5:0]     trim_lp;
    logic [2:0][7:0]     trim_st;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                out_valid;
    logic                sleep_mode;
    logic [2:0][15:0]    gyro_out;
    logic [2:0][9:0]     tc_m;
    logic [2:0][5:0]     lp_m;
    logic [15:0]         usr_m;
    logic [31:0]         rd_val;
    logic                rd_err;
    int                  num_errors = 0;
    int                  checked    = 0;
    int                  cycles     = 0;

    gotr_regs #(.GYRO_LSB_UDPS(LSB)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trim_tc(trim_tc), .trim_lp(trim_lp), .trim_st(trim_st),
        .raw_valid(raw_valid), .gyro_raw(gyro_raw), .temp_delta(temp_delta),
        .gyro_out(gyro_out), .out_valid(out_valid), .sleep_mode(sleep_mode)
    );

    always #25 pclk = ~pclk;

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_smp(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_smp

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask : chk_bit

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ba(input logic [5:0] i);
        return {i, 2'b00};
    endfunction : ba

    // Saturating model of the corrected sample
    function automatic logic [15:0] exp_out(input logic [15:0] r, input logic [9:0] c,
                                            input logic [7:0] t, input logic [15:0] u);
        longint s;
        s = $signed(r) + (($signed(c) * $signed(t) * GAIN) >>> 16) + $signed(u);
        if (s > 32767) s = 32767;
        if (s < -32768) s = -32768;
        return s[15:0];
    endfunction : exp_out

    function automatic logic [2:0][15:0] rr();
        logic [2:0][15:0] r;
        for (int a = 0; a < 3; a++) r[a] = 16'($urandom);
        return r;
    endfunction : rr

    // Request held until pready is sampled high; no latency assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // No timeout here; only the hang guard ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, 4'h1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk_reg($sformatf("reg %h", a), {24'h0, e}, rd_val);
        chk_bit("pslverr", 1'b0, rd_err);
    endtask : rd

    task automatic chk_all();
        for (int a = 0; a < 3; a++) begin
            rd(ba(IDX_TC_HIGH[a]), {lp_m[a], tc_m[a][9:8]});
            rd(ba(IDX_TC_LOW[a]), tc_m[a][7:0]);
            rd(ba(IDX_SELFTEST_CODE_VALUE[a]), trim_st[a]);
        end
        rd(ba(IDX_USR_HIGH), usr_m[15:8]);
        rd(ba(IDX_USR_LOW), usr_m[7:0]);
    endtask : chk_all

    // Sample in c0, result expected one cycle later
    task automatic smp(input logic [2:0][15:0] r, input logic [7:0] t, input logic v);
        @(posedge pclk);
        raw_valid <= 1'b1;
        gyro_raw <= r;
        temp_delta <= t;
        @(posedge pclk);
        raw_valid <= 1'b0;
        @(posedge pclk);
        chk_bit("out_valid", v, out_valid);
        for (int a = 0; a < 3; a++)
            if (v) chk_smp($sformatf("gyro_out %0d", a),
                           exp_out(r[a], tc_m[a], t, (a == 0) ? usr_m : 16'h0),
                           gyro_out[a]);
    endtask : smp

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0]       b;
        logic [2:0][15:0] r;
        logic [7:0]       bad_a [3] = '{8'h11, 8'h44, 8'hFC};
        void'($urandom(32'h245d));
        for (int a = 0; a < 3; a++) begin
            trim_tc[a] = 10'($urandom);
            trim_lp[a] = 6'($urandom);
            trim_st[a] = 8'($urandom);
        end
        trim_tc[2] = 10'h200;
        tc_m = trim_tc;
        lp_m = trim_lp;
        usr_m = 16'h0000;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_bit("sleep_mode", 1'b1, sleep_mode);
        smp(rr(), 8'h05, 1'b0);
        chk_all();
        foreach (bad_a[k]) begin
            apb(1'b0, bad_a[k], 32'h0, 4'h0);
            chk_reg("err prdata", 32'h0, rd_val);
            chk_bit("err pslverr", 1'b1, rd_err);
        end
        wr(ba(IDX_PWR_CTRL), 8'h00);
        @(posedge pclk);
        chk_bit("sleep_mode", 1'b0, sleep_mode);
        rd(ba(IDX_PWR_CTRL), 8'h00);
        repeat (16) smp(rr(), 8'($urandom), 1'b1);
        smp({16'h0000, 16'h8000, 16'h7FFF}, 8'h7F, 1'b1);
        // Zero coefficient on X and Y: temperature must not matter
        for (int a = 0; a < 2; a++) begin
            wr(ba(IDX_TC_HIGH[a]), 8'h00);
            wr(ba(IDX_TC_LOW[a]), 8'h00);
            tc_m[a] = 10'h000;
            lp_m[a] = 6'h00;
        end
        smp(rr(), 8'h40, 1'b1);
        for (int a = 0; a < 3; a++) begin
            b = 8'($urandom);
            wr(ba(IDX_TC_HIGH[a]), b);
            {lp_m[a], tc_m[a][9:8]} = b;
            b = 8'($urandom);
            wr(ba(IDX_TC_LOW[a]), b);
            tc_m[a][7:0] = b;
        end
        apb(1'b1, ba(IDX_TC_LOW[1]), ~{24'h0, tc_m[1][7:0]}, 4'h0);
        chk_all();
        smp(rr(), 8'($urandom), 1'b1);
        // High byte alone first, then the low byte
        b = 8'($urandom);
        wr(ba(IDX_USR_HIGH), b);
        usr_m[15:8] = b;
        smp(rr(), 8'($urandom), 1'b1);
        b = 8'($urandom);
        wr(ba(IDX_USR_LOW), b);
        usr_m[7:0] = b;
        repeat (4) smp(rr(), 8'($urandom), 1'b1);
        // Zero X coefficient and zero raw X: output is the user offset alone
        wr(ba(IDX_TC_HIGH[0]), 8'h00);
        wr(ba(IDX_TC_LOW[0]), 8'h00);
        tc_m[0] = 10'h000;
        lp_m[0] = 6'h00;
        r = rr();
        r[0] = 16'h0000;
        smp(r, 8'($urandom), 1'b1);
        chk_all();
        wr(ba(IDX_PWR_CTRL), 8'h80);
        tc_m = trim_tc;
        lp_m = trim_lp;
        usr_m = 16'h0000;
        chk_all();
        chk_bit("sleep_mode", 1'b1, sleep_mode);
        rd(ba(IDX_PWR_CTRL), 8'h01);
        smp(rr(), 8'h10, 1'b0);
        stop_test();
    end

endmodule : testbench
